// [logic/uvpf_pkg.sv]
// Shared constants, types and decoders of the isochronous video packet FIFO
// Summary of operation
// - Frames leave as equal packets, last one shorter
// - Zero-length packets may separate video frames
// - Slow frame rates always get zero-length packets
// - Packet size register sets full packet length
// - Prefill threshold gates start of new frame
// - Read gap counts 12 MHz cycles per byte
// - One enable switches whole FIFO on/off
// - Writes come only from transfer buffer
// - One packet read attempt per USB interval
// - No read while new frame under threshold, unless FIFO full
// - Read stops at next frame's first byte
// - Read stops when FIFO runs empty
// - Parameters arrive over the two-wire serial bus
// - Command selects register space, may reach engine
// - Data accesses use the last selected space
package uvpf_pkg;

   // Clock rates behind the read pacing
   localparam int unsigned CLK_SYS_HZ   = 100_000_000;
   localparam int unsigned READ_CLK_HZ  = 12_000_000;
   localparam int unsigned ACC_UNIT_HZ  = 1_000_000;
   // Fractional accumulator that turns clk_sys into 12 MHz ticks
   localparam logic [7:0]  ACC_STEP     = 8'(READ_CLK_HZ / ACC_UNIT_HZ);
   localparam logic [7:0]  ACC_WRAP     = 8'(CLK_SYS_HZ / ACC_UNIT_HZ);
   localparam logic [7:0]  ACC_RST      = 8'h00;

   // Buffer geometry and field widths
   localparam int unsigned FIFO_DEPTH_DEF = 16;
   localparam int unsigned DATA_W         = 8;
   localparam int unsigned LEN_W          = 11;
   localparam int unsigned GAP_W          = 8;

   // Values after reset
   localparam logic [LEN_W-1:0] PKT_SIZE_RST = 11'h100;
   localparam logic [LEN_W-1:0] OFFSET_RST   = 11'h010;
   localparam logic [GAP_W-1:0] SPACING_RST  = 8'h0A;
   localparam logic             ACTIVE_RST   = 1'b0;

   // Register indices inside the video FIFO space
   localparam logic [3:0] REG_PKT_LO  = 4'h0;
   localparam logic [3:0] REG_PKT_HI  = 4'h1;
   localparam logic [3:0] REG_OFS_LO  = 4'h2;
   localparam logic [3:0] REG_OFS_HI  = 4'h3;
   localparam logic [3:0] REG_SPACING = 4'h4;
   localparam logic [3:0] REG_ACTIVE  = 4'h5;
   localparam logic [3:0] REG_LEVEL   = 4'h6;
   localparam int unsigned HI_W       = LEN_W - DATA_W;

   // Command byte layout
   localparam int unsigned CMD_SPACE_LSB = 6;
   localparam int unsigned CMD_INDEX_LSB = 0;

   // Register spaces reachable by a command
   typedef enum logic [1:0] {
      SPACE_ENGINE = 2'b00,
      SPACE_FIFO   = 2'b01,
      SPACE_BOTH   = 2'b10,
      SPACE_NONE   = 2'b11
   } uvpf_space_t;

   // Reader states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_GAP  = 2'b01,
      ST_POP  = 2'b10,
      ST_END  = 2'b11
   } uvpf_state_t;

   // One buffered byte with its frame-start marker
   typedef struct packed {
      logic              frame_start;
      logic [DATA_W-1:0] data;
   } uvpf_word_t;

   // One decoded serial-bus access
   typedef struct packed {
      logic              valid;
      logic              is_data;
      logic              write;
      logic [DATA_W-1:0] wdata;
   } uvpf_cfg_req_t;

   // Space forwards to the protocol engine
   function automatic logic uvpf_to_engine(input uvpf_space_t sp);
      uvpf_to_engine = (sp == SPACE_ENGINE) || (sp == SPACE_BOTH);
   endfunction

   // Space reaches the video FIFO registers
   function automatic logic uvpf_to_fifo(input uvpf_space_t sp);
      uvpf_to_fifo = (sp == SPACE_FIFO) || (sp == SPACE_BOTH);
   endfunction

endpackage

// [logic/uvpf_fifo.sv]
// Show-ahead FIFO with valid/ready on both sides and flush
`timescale 1ns/1ps
`default_nettype none
module uvpf_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 16,
   parameter int unsigned LVL_W = $clog2(DEPTH + 1)
) (
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic             flush,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready,
   output logic      [LVL_W-1:0] level
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0]    PTR_LAST = AW'(DEPTH - 1);
   localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];   // Storage words
   logic [AW-1:0]    wr_ptr_reg;    // Next slot to fill
   logic [AW-1:0]    rd_ptr_reg;    // Oldest word
   logic [LVL_W-1:0] count_reg;     // Words held
   logic             push;          // Accepted write
   logic             pop;           // Accepted read

   assign in_ready  = (count_reg != LVL_FULL);
   assign out_valid = (count_reg != '0);
   assign out_data  = mem[rd_ptr_reg];
   assign level     = count_reg;
   assign push      = in_valid && in_ready && !flush;
   assign pop       = out_valid && out_ready && !flush;

   // Data store, no reset needed
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and count, flush empties at once
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else if (flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + LVL_W'(push) - LVL_W'(pop);
      end
   end
endmodule
`default_nettype wire

// [logic/uvpf_top.sv]
// Isochronous video packet FIFO with serial-bus configuration spaces
`timescale 1ns/1ps
`default_nettype none
module uvpf_top #(
   parameter int unsigned FIFO_DEPTH = uvpf_pkg::FIFO_DEPTH_DEF,
   parameter int unsigned LVL_W      = $clog2(FIFO_DEPTH + 1)
) (
   input  wire logic                          clk_sys,
   input  wire logic                          nrst,
   // Transfer buffer write side
   input  wire logic                          wr_valid,
   input  wire logic [uvpf_pkg::DATA_W-1:0]   wr_data,
   input  wire logic                          wr_frame_start,
   output logic                               wr_ready,
   // USB interval pulse from the protocol engine
   input  wire logic                          usb_frame_tick,
   // Packet stream toward the protocol engine
   output logic                               pkt_start,
   output logic                               pkt_byte_valid,
   output logic      [uvpf_pkg::DATA_W-1:0]   pkt_byte,
   output logic                               pkt_end,
   output logic      [uvpf_pkg::LEN_W-1:0]    pkt_len,
   // Decoded serial-bus access
   input  wire uvpf_pkg::uvpf_cfg_req_t       cfg_req,
   output logic                               cfg_rvalid,
   output logic      [uvpf_pkg::DATA_W-1:0]   cfg_rdata,
   // Accesses forwarded to the protocol engine
   output logic                               eng_cmd_valid,
   output logic                               eng_data_valid,
   output logic                               eng_data_write,
   output logic      [uvpf_pkg::DATA_W-1:0]   eng_data
);
   localparam int unsigned DW = uvpf_pkg::DATA_W;
   localparam int unsigned LW = uvpf_pkg::LEN_W;
   localparam int unsigned GW = uvpf_pkg::GAP_W;
   localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(FIFO_DEPTH);
   localparam logic [LW-1:0]    LEN_MAX  = '1;
   localparam int unsigned      HI_W_M1  = uvpf_pkg::HI_W - 1;

   // Configuration state
   logic [LW-1:0]           pkt_size_reg;     // Full packet length
   logic [LW-1:0]           offset_reg;       // Prefill threshold
   logic [GW-1:0]           spacing_reg;      // 12 MHz cycles between reads
   logic                    active_reg;       // FIFO enable
   uvpf_pkg::uvpf_space_t   space_reg;        // Space of last command
   logic [3:0]              index_reg;        // Register pointer in space
   logic [DW-1:0]           cmd_byte_reg;     // Last command byte
   // Reader state
   uvpf_pkg::uvpf_state_t   state_reg;        // Reader state
   logic [LW-1:0]           byte_cnt_reg;     // Bytes sent in packet
   logic [GW-1:0]           gap_cnt_reg;      // Ticks waited
   logic                    last_full_reg;    // Previous packet was full
   logic [7:0]              acc_reg;          // Tick accumulator
   logic                    tick12_reg;       // 12 MHz tick pulse
   // Write-side tracking
   logic [LVL_W-1:0]        starts_reg;       // Frame starts held
   logic [LW-1:0]           frame_wr_cnt_reg; // Bytes written in newest frame
   logic                    wr_ready_reg;     // Registered write ready
   // Output registers
   logic                    pkt_start_reg;
   logic                    pkt_byte_valid_reg;
   logic [DW-1:0]           pkt_byte_reg;
   logic                    pkt_end_reg;
   logic [LW-1:0]           pkt_len_reg;
   logic                    cfg_rvalid_reg;
   logic [DW-1:0]           cfg_rdata_reg;
   logic                    eng_cmd_valid_reg;
   logic                    eng_data_valid_reg;
   logic                    eng_data_write_reg;
   logic [DW-1:0]           eng_data_reg;
   // FIFO wiring
   uvpf_pkg::uvpf_word_t    in_word;          // Marked write word
   uvpf_pkg::uvpf_word_t    head;             // Oldest buffered word
   logic                    fifo_in_ready;    // FIFO has room
   logic                    fifo_out_valid;   // FIFO not empty
   logic [LVL_W-1:0]        level;            // Words held
   logic [LVL_W-1:0]        lvl_next;         // Level after this cycle
   logic                    push;             // Byte accepted
   logic                    pop;              // Byte sent
   logic                    prefill_block;    // New frame still too short
   logic                    boundary;         // Head opens another frame
   logic                    zlp_now;          // Interval gets empty packet
   logic [LW-1:0]           byte_cnt_inc;     // Count after a pop
   logic                    data_acc;         // Data-address access
   logic                    fifo_acc;         // Data access to FIFO space

   assign in_word.frame_start = wr_frame_start;
   assign in_word.data        = wr_data;

   assign push = wr_valid && wr_ready_reg && fifo_in_ready && active_reg;

   assign boundary = head.frame_start && (byte_cnt_reg != '0);

   assign pop = (state_reg == uvpf_pkg::ST_POP) && active_reg && fifo_out_valid && !boundary;

   assign lvl_next     = level + LVL_W'(push) - LVL_W'(pop);
   assign byte_cnt_inc = byte_cnt_reg + 1'b1;

   // hold a young frame, unless full
   assign prefill_block = head.frame_start && (starts_reg == LVL_W'(1))
                          && (frame_wr_cnt_reg < offset_reg) && (level != LVL_FULL);

   // empty packet when nothing to send, or to close a full-ending frame
   assign zlp_now = !active_reg || !fifo_out_valid || prefill_block
                    || (pkt_size_reg == '0) || (last_full_reg && head.frame_start);

   assign data_acc = cfg_req.valid && cfg_req.is_data;
   assign fifo_acc = data_acc && uvpf_pkg::uvpf_to_fifo(space_reg);

   // Byte buffer between transfer buffer and reader
   uvpf_fifo #(
      .WIDTH ($bits(uvpf_pkg::uvpf_word_t)),
      .DEPTH (FIFO_DEPTH),
      .LVL_W (LVL_W)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .flush     (!active_reg),
      .in_valid  (wr_valid && wr_ready_reg && active_reg),
      .in_data   (in_word),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (head),
      .out_ready (pop),
      .level     (level)
   );

   // Write ready follows level after this cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_ready_reg <= 1'b0;
      end else begin
         wr_ready_reg <= (lvl_next != LVL_FULL) || !active_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         starts_reg       <= '0;
         frame_wr_cnt_reg <= '0;
      end else if (!active_reg) begin
         starts_reg       <= '0;
         frame_wr_cnt_reg <= '0;
      end else begin
         // Frame starts held in the buffer
         starts_reg <= starts_reg + LVL_W'(push && wr_frame_start)
                       - LVL_W'(pop && head.frame_start);
         if (push && wr_frame_start) begin
            frame_wr_cnt_reg <= LW'(1);
         end else if (push && (frame_wr_cnt_reg != LEN_MAX)) begin
            frame_wr_cnt_reg <= frame_wr_cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         acc_reg    <= uvpf_pkg::ACC_RST;
         tick12_reg <= 1'b0;
      end else if (acc_reg >= uvpf_pkg::ACC_WRAP - uvpf_pkg::ACC_STEP) begin
         acc_reg    <= acc_reg + uvpf_pkg::ACC_STEP - uvpf_pkg::ACC_WRAP;
         tick12_reg <= 1'b1;
      end else begin
         acc_reg    <= acc_reg + uvpf_pkg::ACC_STEP;
         tick12_reg <= 1'b0;
      end
   end

   // Reader sequencing and counters
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_reg     <= uvpf_pkg::ST_IDLE;
         byte_cnt_reg  <= '0;
         gap_cnt_reg   <= '0;
         last_full_reg <= 1'b0;
      end else begin
         case (state_reg)
            uvpf_pkg::ST_IDLE: begin
               if (usb_frame_tick) begin
                  byte_cnt_reg <= '0;
                  gap_cnt_reg  <= '0;
                  // empty packet also closes a full-ending frame
                  if (zlp_now) begin
                     state_reg     <= uvpf_pkg::ST_END;
                     last_full_reg <= 1'b0;
                  end else begin
                     state_reg <= uvpf_pkg::ST_GAP;
                  end
               end
            end
            uvpf_pkg::ST_GAP: begin
               if (!active_reg) begin
                  state_reg <= uvpf_pkg::ST_END;
               end else if (tick12_reg) begin
                  if (gap_cnt_reg >= spacing_reg) begin
                     state_reg <= uvpf_pkg::ST_POP;
                  end else begin
                     gap_cnt_reg <= gap_cnt_reg + 1'b1;
                  end
               end
            end
            // stop at full size or short
            uvpf_pkg::ST_POP: begin
               if (!pop) begin
                  state_reg     <= uvpf_pkg::ST_END;
                  last_full_reg <= 1'b0;
               end else if (byte_cnt_inc == pkt_size_reg) begin
                  byte_cnt_reg  <= byte_cnt_inc;
                  last_full_reg <= 1'b1;
                  state_reg     <= uvpf_pkg::ST_END;
               end else begin
                  byte_cnt_reg <= byte_cnt_inc;
                  gap_cnt_reg  <= '0;
                  state_reg    <= uvpf_pkg::ST_GAP;
               end
            end
            uvpf_pkg::ST_END: begin
               state_reg <= uvpf_pkg::ST_IDLE;
            end
            default: begin
               state_reg <= uvpf_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pkt_start_reg      <= 1'b0;
         pkt_byte_valid_reg <= 1'b0;
         pkt_byte_reg       <= '0;
         pkt_end_reg        <= 1'b0;
         pkt_len_reg        <= '0;
      end else begin
         pkt_start_reg      <= (state_reg == uvpf_pkg::ST_IDLE) && usb_frame_tick;
         pkt_byte_valid_reg <= pop;
         pkt_end_reg        <= (state_reg == uvpf_pkg::ST_END);
         // Data byte sent
         if (pop) begin
            pkt_byte_reg <= head.data;
         end
         // Length reported with the end pulse
         if (state_reg == uvpf_pkg::ST_END) begin
            pkt_len_reg <= byte_cnt_reg;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         space_reg    <= uvpf_pkg::SPACE_NONE;
         index_reg    <= '0;
         cmd_byte_reg <= '0;
      end else if (cfg_req.valid && !cfg_req.is_data && cfg_req.write) begin
         space_reg    <= uvpf_pkg::uvpf_space_t'(cfg_req.wdata[uvpf_pkg::CMD_SPACE_LSB +: 2]);
         index_reg    <= cfg_req.wdata[uvpf_pkg::CMD_INDEX_LSB +: 4];
         cmd_byte_reg <= cfg_req.wdata;
      end else if (fifo_acc) begin
         index_reg <= index_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pkt_size_reg <= uvpf_pkg::PKT_SIZE_RST;
         offset_reg   <= uvpf_pkg::OFFSET_RST;
         spacing_reg  <= uvpf_pkg::SPACING_RST;
         active_reg   <= uvpf_pkg::ACTIVE_RST;
      end else if (fifo_acc && cfg_req.write) begin
         case (index_reg)
            uvpf_pkg::REG_PKT_LO:  pkt_size_reg[DW-1:0]  <= cfg_req.wdata;
            uvpf_pkg::REG_PKT_HI:  pkt_size_reg[LW-1:DW] <= cfg_req.wdata[HI_W_M1:0];
            uvpf_pkg::REG_OFS_LO:  offset_reg[DW-1:0]    <= cfg_req.wdata;
            uvpf_pkg::REG_OFS_HI:  offset_reg[LW-1:DW]   <= cfg_req.wdata[HI_W_M1:0];
            uvpf_pkg::REG_SPACING: spacing_reg           <= cfg_req.wdata;
            uvpf_pkg::REG_ACTIVE:  active_reg            <= cfg_req.wdata[0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cfg_rvalid_reg <= 1'b0;
         cfg_rdata_reg  <= '0;
      end else begin
         cfg_rvalid_reg <= cfg_req.valid && !cfg_req.write;
         if (cfg_req.valid && !cfg_req.write) begin
            if (!cfg_req.is_data) begin
               cfg_rdata_reg <= cmd_byte_reg;
            end else if (uvpf_pkg::uvpf_to_fifo(space_reg)) begin
               case (index_reg)
                  uvpf_pkg::REG_PKT_LO:  cfg_rdata_reg <= pkt_size_reg[DW-1:0];
                  uvpf_pkg::REG_PKT_HI:  cfg_rdata_reg <= DW'(pkt_size_reg[LW-1:DW]);
                  uvpf_pkg::REG_OFS_LO:  cfg_rdata_reg <= offset_reg[DW-1:0];
                  uvpf_pkg::REG_OFS_HI:  cfg_rdata_reg <= DW'(offset_reg[LW-1:DW]);
                  uvpf_pkg::REG_SPACING: cfg_rdata_reg <= spacing_reg;
                  uvpf_pkg::REG_ACTIVE:  cfg_rdata_reg <= DW'(active_reg);
                  uvpf_pkg::REG_LEVEL:   cfg_rdata_reg <= DW'(level);
                  default:               cfg_rdata_reg <= '0;
               endcase
            end else begin
               // Engine-only and SPACE_NONE spaces answer zero here
               cfg_rdata_reg <= '0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         eng_cmd_valid_reg  <= 1'b0;
         eng_data_valid_reg <= 1'b0;
         eng_data_write_reg <= 1'b0;
         eng_data_reg       <= '0;
      end else begin
         eng_cmd_valid_reg <= cfg_req.valid && !cfg_req.is_data && cfg_req.write
                              && uvpf_pkg::uvpf_to_engine(uvpf_pkg::uvpf_space_t'(
                                 cfg_req.wdata[uvpf_pkg::CMD_SPACE_LSB +: 2]));
         eng_data_valid_reg <= data_acc && uvpf_pkg::uvpf_to_engine(space_reg);
         if (cfg_req.valid) begin
            eng_data_write_reg <= cfg_req.write;
            eng_data_reg       <= cfg_req.wdata;
         end
      end
   end

   // Outputs straight from registers
   assign wr_ready       = wr_ready_reg;
   assign pkt_start      = pkt_start_reg;
   assign pkt_byte_valid = pkt_byte_valid_reg;
   assign pkt_byte       = pkt_byte_reg;
   assign pkt_end        = pkt_end_reg;
   assign pkt_len        = pkt_len_reg;
   assign cfg_rvalid     = cfg_rvalid_reg;
   assign cfg_rdata      = cfg_rdata_reg;
   assign eng_cmd_valid  = eng_cmd_valid_reg;
   assign eng_data_valid = eng_data_valid_reg;
   assign eng_data_write = eng_data_write_reg;
   assign eng_data       = eng_data_reg;
endmodule
`default_nettype wire

// [test/uvpf_properties.sv]
// Port timing checker of the video packet FIFO
`timescale 1ns/1ps
`default_nettype none
module uvpf_properties (
   input wire logic                    clk_sys,
   input wire logic                    nrst,
   input wire logic                    usb_frame_tick,
   input wire logic                    pkt_start,
   input wire logic                    pkt_byte_valid,
   input wire logic                    pkt_end,
   input wire logic [10:0]             pkt_len,
   input wire uvpf_pkg::uvpf_cfg_req_t cfg_req,
   input wire logic                    cfg_rvalid,
   input wire logic                    eng_cmd_valid,
   input wire logic                    eng_data_valid
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Read request and any command write
   sequence s_rd; cfg_req.valid && !cfg_req.write; endsequence
   sequence s_cmd; cfg_req.valid && !cfg_req.is_data && cfg_req.write; endsequence
   sequence s_empty; pkt_start ##1 pkt_end; endsequence
   a_tick_to_start: assert property (pkt_start |-> $past(usb_frame_tick))
      else $error("packet start without interval tick");
   a_byte_gap_min: assert property (pkt_byte_valid |=> !pkt_byte_valid [*5])
      else $error("bytes closer than read spacing");
   a_len_with_end: assert property (pkt_len != $past(pkt_len) |-> pkt_end)
      else $error("packet length moved without end");
   a_empty_len_zero: assert property (s_empty |-> pkt_len == 11'h000)
      else $error("quick packet with nonzero length");
   a_read_answer: assert property (s_rd |=> cfg_rvalid)
      else $error("read not answered next cycle");
   a_rvalid_cause: assert property (cfg_rvalid |-> $past(cfg_req.valid && !cfg_req.write))
      else $error("read answer without request");
   a_cmd_route: assert property (s_cmd ##0 !cfg_req.wdata[6] |=> eng_cmd_valid)
      else $error("engine command not forwarded");
   a_cmd_only: assert property (eng_cmd_valid |-> $past(cfg_req.valid && !cfg_req.is_data))
      else $error("engine command without command write");
   a_eng_data: assert property (eng_data_valid |-> $past(cfg_req.valid && cfg_req.is_data))
      else $error("engine data without data access");
endmodule
bind uvpf_top uvpf_properties u_props (.clk_sys(clk_sys), .nrst(nrst),
   .usb_frame_tick(usb_frame_tick), .pkt_start(pkt_start), .pkt_byte_valid(pkt_byte_valid),
   .pkt_end(pkt_end), .pkt_len(pkt_len), .cfg_req(cfg_req), .cfg_rvalid(cfg_rvalid),
   .eng_cmd_valid(eng_cmd_valid), .eng_data_valid(eng_data_valid));
`default_nettype wire

// [test/uvpf_src.sv]
// Transfer buffer model that offers frame bytes
`timescale 1ns/1ps
`default_nettype none
module uvpf_src (
   input  wire logic       clk_sys,
   input  wire logic       wr_ready,
   output logic            wr_valid,
   output logic      [7:0] wr_data,
   output logic            wr_frame_start
);
   initial begin
      wr_valid = 1'b0;
      wr_data = 8'h00;
      wr_frame_start = 1'b0;
   end
   // bytes held until taken, first marked if sof
   task automatic send(input logic [7:0] base, input int n, input logic sof);
      for (int i = 0; i < n; i++) begin
         if (i == 0) @(posedge clk_sys);
         wr_valid <= 1'b1;
         wr_data <= base + 8'(i);
         wr_frame_start <= sof && (i == 0);
         do @(posedge clk_sys); while (wr_ready !== 1'b1);
      end
      wr_valid <= 1'b0;
      wr_data <= ~wr_data;
      wr_frame_start <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [test/uvpf_top_tb.sv]
// Self-checking bench of the video packet FIFO
`timescale 1ns/1ps
`default_nettype none
module uvpf_top_tb;
   logic clk_sys = 1'b0, nrst = 1'b0, tick = 1'b0;
   logic wr_valid, wr_fs, wr_ready, p_st, p_bv, p_end, rv, ecv, edv, edw;
   logic [7:0] wr_data, p_byte, rdata, edata, q[$];
   logic [10:0] p_len;
   uvpf_pkg::uvpf_cfg_req_t cfg_req = '0;
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   // spacing 1 stays below 3000 over size 4
   logic [7:0] regs [6] = '{8'h04, 8'h00, 8'h02, 8'h00, 8'h01, 8'h01};
   uvpf_top dut (.clk_sys(clk_sys), .nrst(nrst), .wr_valid(wr_valid), .wr_data(wr_data),
      .wr_frame_start(wr_fs), .wr_ready(wr_ready), .usb_frame_tick(tick), .pkt_start(p_st),
      .pkt_byte_valid(p_bv), .pkt_byte(p_byte), .pkt_end(p_end), .pkt_len(p_len),
      .cfg_req(cfg_req), .cfg_rvalid(rv), .cfg_rdata(rdata), .eng_cmd_valid(ecv),
      .eng_data_valid(edv), .eng_data_write(edw), .eng_data(edata));
   uvpf_src u_src (.clk_sys(clk_sys), .wr_ready(wr_ready), .wr_valid(wr_valid),
      .wr_data(wr_data), .wr_frame_start(wr_fs));
   always #5 clk_sys = ~clk_sys;
   // Collect packet bytes; cut a hang short
   always @(posedge clk_sys) begin
      if (p_bv === 1'b1) q.push_back(p_byte);
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One serial-bus access; a read checks its answer
   task automatic cfg(input logic d, input logic w, input logic [7:0] v, input logic [7:0] e);
      @(posedge clk_sys);
      cfg_req <= '{1'b1, d, w, v};
      @(posedge clk_sys);
      cfg_req <= '0;
      #1;
      if (!w) check("cfg_read", {2'b00, rv, rdata}, {3'b001, e});
   endtask
   // One interval tick, then the packet is compared
   task automatic pkt(input int n, input logic [7:0] b);
      int i;
      q.delete();
      @(posedge clk_sys);
      tick <= 1'b1;
      @(posedge clk_sys);
      tick <= 1'b0;
      for (i = 0; i < 3000 && p_end !== 1'b1; i++) @(posedge clk_sys) #1;
      check("pkt_len", p_len, 11'(n));
      check("pkt_count", 11'(q.size()), 11'(n));
      foreach (q[k]) check("pkt_byte", {3'b000, q[k]}, {3'b000, b + 8'(k)});
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      cfg(1'b0, 1'b1, 8'h40, 8'h00);
      foreach (regs[k]) cfg(1'b1, 1'b1, regs[k], 8'h00);
      cfg(1'b0, 1'b1, 8'h40, 8'h00);
      foreach (regs[k]) cfg(1'b1, 1'b0, 8'h00, regs[k]);
      cfg(1'b1, 1'b0, 8'h00, 8'h00);
      cfg(1'b0, 1'b0, 8'h00, 8'h40);
      cfg(1'b0, 1'b1, 8'h85, 8'h00);
      cfg(1'b1, 1'b1, 8'h01, 8'h00);
      check("eng_data", {2'b00, edw, edata}, 11'h101);
      cfg(1'b0, 1'b1, 8'hC0, 8'h00);
      cfg(1'b1, 1'b0, 8'h00, 8'h00);
      cfg(1'b0, 1'b1, 8'h06, 8'h00);
      check("eng_cmd", {10'h000, ecv}, 11'h001);
      cfg(1'b1, 1'b0, 8'h00, 8'h00);
      $display("test config done");
      u_src.send(8'h10, 6, 1'b1);
      u_src.send(8'h20, 1, 1'b1);
      pkt(4, 8'h10);
      pkt(2, 8'h14);
      pkt(0, 8'h00);
      u_src.send(8'h21, 2, 1'b0);
      pkt(3, 8'h20);
      pkt(0, 8'h00);
      u_src.send(8'h30, 16, 1'b1);
      repeat (2) @(posedge clk_sys) #1;
      check("wr_ready_full", {10'h000, wr_ready}, 11'h000);
      cfg(1'b0, 1'b1, 8'h46, 8'h00);
      cfg(1'b1, 1'b0, 8'h00, 8'h10);
      for (int k = 0; k < 4; k++) pkt(4, 8'h30 + 8'(4 * k));
      u_src.send(8'h40, 3, 1'b1);
      pkt(0, 8'h00);
      $display("test stream done");
      cfg(1'b0, 1'b1, 8'h45, 8'h00);
      cfg(1'b1, 1'b1, 8'h00, 8'h00);
      pkt(0, 8'h00);
      u_src.send(8'h50, 2, 1'b1);
      cfg(1'b0, 1'b1, 8'h45, 8'h00);
      cfg(1'b1, 1'b1, 8'h01, 8'h00);
      pkt(0, 8'h00);
      $display("test flush done");
      end_sim();
   end
endmodule
`default_nettype wire
